// ### logic/mpt_time_base.sv
// Motor PWM time base with duty channels and register port
//
// Contract
// - 15-bit up/down counter, prescaler, postscaler.
// - Count register top bit shows direction.
// - Counts only when enabled; disable freezes.
// - Period match resets or reverses next tick.
// - Zero period halts counting and events.
// - Mode 00 free-running, postscaled events.
// - Mode 01 single shot, self-disables.
// - Mode 10 up/down, event at zero.
// - Mode 11 events at zero and match.
// - Prescaler divides by 1, 4, 16, 64.
// - Count or control writes clear prescaler.
// - Postscaler ratio one to sixteen.
// - Count or control writes clear postscaler.
// - Period buffer loads at reset points.
// - Disabled time base copies period continuously.
// - Up/down period is twice edge period.
// - Edge output active at zero, off at duty.
// - Edge duty zero off, above period on.
// - Centre output on going down, off up.
// - Centre duty zero off, period on.
// - One to three channels, complementary pairs.
// - Duty buffers load at period reset.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module mpt_time_base #(
  parameter int NUM_CH = 3
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [7:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [15:0]       o_rdata,
  output logic                   o_tb_event,
  output logic      [NUM_CH-1:0] o_pair_high_out,
  output logic      [NUM_CH-1:0] o_pair_low_out
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
      $error("NUM_CH must be 1 to 3");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [14:0] time_base_count;
  logic        count_direction_flag;
  logic        time_base_enable;
  logic [1:0]  count_mode_select;
  logic [1:0]  prescale_select;
  logic [3:0]  postscale_select;
  logic [14:0] period_buffer;
  logic [14:0] period_value;
  logic [5:0]  pre_cnt;
  logic [3:0]  post_cnt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_ctrl  = (i_addr == mpt_pkg::OFS_CONTROL);
  wire sel_per   = (i_addr == mpt_pkg::OFS_PERIOD);
  wire sel_cnt   = (i_addr == mpt_pkg::OFS_COUNT);
  wire sel_d1    = (i_addr == mpt_pkg::OFS_DUTY1);
  wire sel_d2    = (i_addr == mpt_pkg::OFS_DUTY2);
  wire sel_d3    = (i_addr == mpt_pkg::OFS_DUTY3);
  wire wr_ctrl   = i_wr && sel_ctrl;
  wire wr_per    = i_wr && sel_per;
  wire wr_cnt    = i_wr && sel_cnt;
  wire [2:0] wr_duty = {i_wr && sel_d3, i_wr && sel_d2, i_wr && sel_d1};

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [5:0] pre_limit;
  always_comb begin
    unique case (prescale_select)
      2'h0: pre_limit = mpt_pkg::PRE_LIM_1;
      2'h1: pre_limit = mpt_pkg::PRE_LIM_4;
      2'h2: pre_limit = mpt_pkg::PRE_LIM_16;
      2'h3: pre_limit = mpt_pkg::PRE_LIM_64;
    endcase
  end

  wire pre_tick  = (pre_cnt == pre_limit);
  wire per_zero  = (period_value == mpt_pkg::COUNT_ZERO);
  wire tick      = time_base_enable && pre_tick && !per_zero;
  wire centre    = count_mode_select[1];
  wire at_match  = (time_base_count == period_value);
  wire at_zero   = (time_base_count == mpt_pkg::COUNT_ZERO);

  // ----------------------------------------------------------------
  // Counting events
  // ----------------------------------------------------------------
  // match acts on tick
  wire edge_wrap  = tick && !centre && at_match;
  wire turn_down  = tick && centre && !count_direction_flag && at_match;
  wire turn_up    = tick && centre && count_direction_flag && at_zero;
  wire mode_free  = (count_mode_select == mpt_pkg::MODE_FREE);
  wire mode_one   = (count_mode_select == mpt_pkg::MODE_SINGLE);
  wire mode_ud    = (count_mode_select == mpt_pkg::MODE_UPDOWN);
  wire mode_dbl   = (count_mode_select == mpt_pkg::MODE_DOUBLE);

  wire post_event = (mode_free && edge_wrap) || (mode_ud && turn_up);
  wire raw_event  = (mode_one && edge_wrap) ||
                    (mode_dbl && (turn_up || turn_down));
  wire post_hit   = post_event && (post_cnt == postscale_select);

  wire reload     = edge_wrap || turn_up;
  wire duty_load  = !time_base_enable || edge_wrap || turn_up ||
                    (mode_dbl && turn_down);

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  logic [14:0] next_count;
  logic        next_dir;
  always_comb begin
    next_count = time_base_count;
    next_dir   = count_direction_flag;
    if (tick) begin
      if (!centre) begin
        if (at_match) next_count = mpt_pkg::COUNT_ZERO;
        else next_count = time_base_count + mpt_pkg::COUNT_ONE;
        next_dir = 1'b0;
      end else if (!count_direction_flag) begin
        if (at_match) next_dir = 1'b1;
        else next_count = time_base_count + mpt_pkg::COUNT_ONE;
      end else begin
        if (at_zero) next_dir = 1'b0;
        else next_count = time_base_count - mpt_pkg::COUNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      time_base_count      <= mpt_pkg::COUNT_ZERO;
      count_direction_flag <= 1'b0;
    end else if (wr_cnt) begin
      // Direction is read-only, so a count write keeps it
      time_base_count <= i_wdata[14:0];
    end else begin
      time_base_count      <= next_count;
      count_direction_flag <= next_dir;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      time_base_enable  <= 1'b0;
      count_mode_select <= mpt_pkg::MODE_FREE;
      prescale_select   <= 2'h0;
      postscale_select  <= mpt_pkg::POST_ZERO;
    end else if (wr_ctrl) begin
      // Software write wins over the single-shot clear
      time_base_enable  <= i_wdata[mpt_pkg::CTL_ENABLE_BIT];
      count_mode_select <= i_wdata[mpt_pkg::CTL_MODE_LSB +: 2];
      prescale_select   <= i_wdata[mpt_pkg::CTL_PRE_LSB +: 2];
      postscale_select  <= i_wdata[mpt_pkg::CTL_POST_LSB +: 4];
    end else if (mode_one && edge_wrap) begin
      time_base_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Prescale and postscale counters
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || wr_cnt || wr_ctrl) begin
      pre_cnt <= mpt_pkg::PRE_ZERO;
    end else if (!time_base_enable || pre_tick) begin
      pre_cnt <= mpt_pkg::PRE_ZERO;
    end else begin
      pre_cnt <= pre_cnt + mpt_pkg::PRE_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || wr_cnt || wr_ctrl) begin
      post_cnt <= mpt_pkg::POST_ZERO;
    end else if (post_hit) begin
      post_cnt <= mpt_pkg::POST_ZERO;
    end else if (post_event) begin
      post_cnt <= post_cnt + mpt_pkg::POST_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Event pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tb_event <= 1'b0;
    end else begin
      o_tb_event <= post_hit || raw_event;
    end
  end

  // ----------------------------------------------------------------
  // Period double buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      period_buffer <= mpt_pkg::COUNT_ZERO;
      period_value  <= mpt_pkg::COUNT_ZERO;
    end else begin
      if (wr_per) period_buffer <= i_wdata[14:0];
      if (!time_base_enable) period_value <= period_buffer;
      else if (reload) period_value <= period_buffer;
    end
  end

  // ----------------------------------------------------------------
  // Duty channels
  // ----------------------------------------------------------------
  logic [14:0] duty_buf [NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      mpt_duty_channel u_ch (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_wr_buf   (wr_duty[ch]),
        .i_wdata    (i_wdata[14:0]),
        .i_load     (duty_load),
        .i_count    (time_base_count),
        .i_dir      (count_direction_flag),
        .i_period   (period_value),
        .i_centre   (centre),
        .o_duty_buf (duty_buf[ch]),
        .o_high     (o_pair_high_out[ch]),
        .o_low      (o_pair_low_out[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [15:0] rd_ctrl = {time_base_enable, 7'h00, postscale_select,
                         prescale_select, count_mode_select};
  wire [15:0] rd_cnt  = {count_direction_flag, time_base_count};
  wire [15:0] rd_per  = {1'b0, period_buffer};
  wire [15:0] rd_d1   = {1'b0, duty_buf[0]};
  // Absent channels read as zero on the small instance
  wire [15:0] rd_d2   = (NUM_CH > 1) ? {1'b0, duty_buf[NUM_CH > 1 ? 1 : 0]}
                                     : mpt_pkg::RDATA_ZERO;
  wire [15:0] rd_d3   = (NUM_CH > 2) ? {1'b0, duty_buf[NUM_CH > 2 ? 2 : 0]}
                                     : mpt_pkg::RDATA_ZERO;

  wire [15:0] rd_mux  = sel_ctrl ? rd_ctrl :
                        sel_per  ? rd_per  :
                        sel_cnt  ? rd_cnt  :
                        sel_d1   ? rd_d1   :
                        sel_d2   ? rd_d2   :
                        sel_d3   ? rd_d3   : mpt_pkg::RDATA_ZERO;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= mpt_pkg::RDATA_ZERO;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= mpt_pkg::RDATA_ZERO;
    end
  end

endmodule // mpt_time_base

// ### logic/mpt_pkg.sv
// Shared constants for the motor PWM time base
package mpt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int COUNT_W = 15;
  localparam int PRE_W   = 6;
  localparam int POST_W  = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIOD  = 8'h04;
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_DUTY1   = 8'h0C;
  localparam logic [7:0] OFS_DUTY2   = 8'h10;
  localparam logic [7:0] OFS_DUTY3   = 8'h14;

  // ----------------------------------------------------------------
  // Control and count register fields
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_POST_LSB   = 4;
  localparam int CTL_PRE_LSB    = 2;
  localparam int CTL_MODE_LSB   = 0;
  localparam int DIR_BIT        = 15;

  // ----------------------------------------------------------------
  // Count modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FREE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDOWN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_LIM_1  = 6'h00;
  localparam logic [5:0] PRE_LIM_4  = 6'h03;
  localparam logic [5:0] PRE_LIM_16 = 6'h0F;
  localparam logic [5:0] PRE_LIM_64 = 6'h3F;

  // ----------------------------------------------------------------
  // Reset values and increments
  // ----------------------------------------------------------------
  localparam logic [14:0] COUNT_ZERO  = 15'h0000;
  localparam logic [14:0] COUNT_ONE   = 15'h0001;
  localparam logic [5:0]  PRE_ZERO    = 6'h00;
  localparam logic [5:0]  PRE_ONE     = 6'h01;
  localparam logic [3:0]  POST_ZERO   = 4'h0;
  localparam logic [3:0]  POST_ONE    = 4'h1;
  localparam logic [15:0] RDATA_ZERO  = 16'h0000;

endpackage

// ### logic/mpt_duty_channel.sv
// One duty comparison channel with buffered duty and output pair
`timescale 1ns/1ps

module mpt_duty_channel (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_buf,
  input  wire logic [14:0] i_wdata,
  input  wire logic        i_load,
  input  wire logic [14:0] i_count,
  input  wire logic        i_dir,
  input  wire logic [14:0] i_period,
  input  wire logic        i_centre,
  output logic      [14:0] o_duty_buf,
  output logic             o_high,
  output logic             o_low
);

  logic [14:0] duty_active;
  logic        next_out;
  wire         hit_duty = (i_count == duty_active);
  wire         duty_zero = (duty_active == mpt_pkg::COUNT_ZERO);
  wire         at_zero  = (i_count == mpt_pkg::COUNT_ZERO);

  // ----------------------------------------------------------------
  // Compare decision
  // ----------------------------------------------------------------
  always_comb begin
    next_out = o_high;
    if (i_centre) begin
      if (hit_duty && i_dir) next_out = 1'b1;
      if (hit_duty && !i_dir) next_out = 1'b0;
      if (duty_active == i_period) next_out = 1'b1;
      if (duty_zero) next_out = 1'b0;
    end else begin
      if (at_zero) next_out = 1'b1;
      if (hit_duty) next_out = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_duty_buf  <= mpt_pkg::COUNT_ZERO;
      duty_active <= mpt_pkg::COUNT_ZERO;
      o_high      <= 1'b0;
      o_low       <= 1'b1;
    end else begin
      if (i_wr_buf) o_duty_buf <= i_wdata;
      if (i_load) duty_active <= o_duty_buf;
      o_high <= next_out;
      o_low  <= ~next_out;
    end
  end

endmodule // mpt_duty_channel

// ### verif/mpt_time_base_sva.sv
// Port assertions for the motor PWM time base
`timescale 1ns/1ps

module mpt_time_base_chk #(
  parameter int NUM_CH = 3
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [7:0]        i_addr,
  input wire logic [15:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [15:0]       o_rdata,
  input wire logic              o_tb_event,
  input wire logic [NUM_CH-1:0] o_pair_high_out,
  input wire logic [NUM_CH-1:0] o_pair_low_out
);
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire logic wr_ctl = i_wr && i_addr == mpt_pkg::OFS_CONTROL;
  wire logic rd_ctl = i_rd && i_addr == mpt_pkg::OFS_CONTROL;
  wire logic wr_per = i_wr && i_addr == mpt_pkg::OFS_PERIOD;
  wire logic rd_per = i_rd && i_addr == mpt_pkg::OFS_PERIOD;
  wire logic wr_cnt = i_wr && i_addr == mpt_pkg::OFS_COUNT;
  wire logic rd_cnt = i_rd && i_addr == mpt_pkg::OFS_COUNT;
  wire logic wr_dty = i_wr && i_addr == mpt_pkg::OFS_DUTY1;
  wire logic rd_dty = i_rd && i_addr == mpt_pkg::OFS_DUTY1;
  wire logic rd_map = rd_ctl || rd_per || rd_cnt || rd_dty || (i_rd && (i_addr == 8'h10
                      || i_addr == 8'h14));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  rdata_quiet_a: assert property (!rd_map |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  pair_compl_a: assert property (o_pair_low_out == ~o_pair_high_out)
    else $error("low output is not the complement of high");
  event_single_a: assert property (o_tb_event |=> !o_tb_event)
    else $error("event pulse longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=>
    (o_pair_high_out == '0 && !o_tb_event && o_rdata == 16'h0000))
    else $error("outputs not quiet after reset");
  off_quiet_a: assert property ((wr_ctl && !i_wdata[15]) ##1 !wr_ctl |=> !o_tb_event)
    else $error("event while time base disabled");
  ctl_back_a: assert property (wr_ctl ##1 rd_ctl |=>
    o_rdata == ($past(i_wdata, 2) & 16'h80FF))
    else $error("control fields not kept");
  per_buf_a: assert property (wr_per ##1 rd_per |=>
    o_rdata == {1'b0, $past(i_wdata[14:0], 2)})
    else $error("period buffer not kept");
  cnt_load_a: assert property (wr_cnt ##1 rd_cnt |=>
    o_rdata[14:0] == $past(i_wdata[14:0], 2))
    else $error("count write not taken");
  duty_buf_a: assert property (wr_dty ##1 rd_dty |=>
    o_rdata == {1'b0, $past(i_wdata[14:0], 2)})
    else $error("duty buffer not kept");

  event_seen_c: cover property (o_tb_event);
  high_rise_c: cover property ($rose(o_pair_high_out[0]));
  down_read_c: cover property (rd_cnt ##1 o_rdata[15]);
endmodule // mpt_time_base_chk

// ### verif/mpt_power_stage.sv
// Behavioural half-bridge power stage on each output pair
`timescale 1ns/1ps

module mpt_power_stage #(
  parameter int NUM_CH = 3
) (
  input  wire logic [NUM_CH-1:0] i_high,
  input  wire logic [NUM_CH-1:0] i_low,
  output logic      [NUM_CH-1:0] o_phase,
  output logic                   o_fault
);
  // complementary pair drive
  // Phase node follows the upper switch only when the lower one is off
  assign o_phase = i_high & ~i_low;
  // Both on shorts the rail; both off leaves the node floating
  assign o_fault = |(i_high & i_low) || |(~i_high & ~i_low);
endmodule // mpt_power_stage

// ### verif/mpt_time_base_tb_top.sv
// Self-checking bench for the motor PWM time base
`timescale 1ns/1ps

module mpt_time_base_tb_top;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} mpt_row_type;
  typedef struct packed {logic [15:0] c; logic [15:0] n;} mpt_mode_type;

  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        evt;
  logic [2:0]  high;
  logic [2:0]  low;
  logic [2:0]  phase;
  logic        fault;
  int          fail_count;
  int          comparisons;
  int          hc [3];
  int          ev;
  int          flt;
  int          n;
  logic [15:0] v1;
  logic [15:0] v2;

  // Bit 15 of count and the unused top bits never stick
  mpt_row_type rows [7] = '{
    '{mpt_pkg::OFS_CONTROL, 16'h00F6, 16'h00F6}, '{mpt_pkg::OFS_PERIOD, 16'hFFFF, 16'h7FFF},
    '{mpt_pkg::OFS_COUNT, 16'hFFFF, 16'h7FFF}, '{mpt_pkg::OFS_DUTY1, 16'h1234, 16'h1234},
    '{mpt_pkg::OFS_DUTY2, 16'h8001, 16'h0001}, '{mpt_pkg::OFS_DUTY3, 16'h7FFF, 16'h7FFF},
    '{8'h18, 16'hABCD, 16'h0000}};
  // Period 4: free, prescale 4/16/64, postscale 4, up/down, double
  mpt_mode_type modes [9] = '{
    '{16'h8000, 16'h0005}, '{16'h8004, 16'h0014}, '{16'h8008, 16'h0050},
    '{16'h800C, 16'h0140}, '{16'h8030, 16'h0014}, '{16'h8002, 16'h000A},
    '{16'h8012, 16'h0014}, '{16'h8003, 16'h0005}, '{16'h8033, 16'h0005}};

  mpt_time_base #(.NUM_CH(3)) DUT (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_tb_event(evt), .o_pair_high_out(high),
    .o_pair_low_out(low));
  mpt_power_stage #(.NUM_CH(3)) stage (.i_high(high), .i_low(low), .o_phase(phase),
    .o_fault(fault));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Strobe stays up at return so back-to-back accesses need no gap
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [15:0] q);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask

  task automatic idle(input int k);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (k) @(posedge clk);
  endtask

  task automatic meas(input int k);
    hc = '{0, 0, 0};
    ev = 0;
    flt = 0;
    idle(0);
    repeat (k) begin
      @(negedge clk);
      for (int i = 0; i < 3; i++) hc[i] += (phase[i] === 1'b1);
      ev += (evt === 1'b1);
      flt += (fault !== 1'b0);
      @(posedge clk);
    end
  endtask

  task automatic wait_evt(output int k);
    k = 0;
    idle(0);
    do begin
      @(negedge clk);
      k++;
    end while (evt !== 1'b1 && k < 800);
    if (k >= 800) begin
      fail_count++;
      $display("ERROR event wait expected 1 seen 0");
      end_sim;
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic cfg(input logic [15:0] c, p, d1, d2, d3);
    wreg(mpt_pkg::OFS_CONTROL, 16'h0000);
    wreg(mpt_pkg::OFS_COUNT, 16'h0000);
    wreg(mpt_pkg::OFS_PERIOD, p);
    wreg(mpt_pkg::OFS_DUTY1, d1);
    wreg(mpt_pkg::OFS_DUTY2, d2);
    wreg(mpt_pkg::OFS_DUTY3, d3);
    wreg(mpt_pkg::OFS_CONTROL, c);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(mpt_pkg::OFS_COUNT, v1);
    chk("count after reset", 16'h0000, v1);
    chk("low after reset", 16'h0007, {13'h0000, low});
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, v1);
      chk("register", rows[i].e, v1);
    end
    $display("test registers done");
    cfg(16'h8000, 16'h0004, 16'h0002, 16'h0000, 16'h0005);
    wait_evt(n);
    meas(10);
    chk("edge duty 2", 16'h0004, 16'(hc[0]));
    chk("edge duty 0", 16'h0000, 16'(hc[1]));
    chk("edge duty above", 16'h000A, 16'(hc[2]));
    chk("edge events", 16'h0002, 16'(ev));
    wreg(mpt_pkg::OFS_PERIOD, 16'h0009);
    wreg(mpt_pkg::OFS_DUTY1, 16'h0007);
    wait_evt(n);
    wait_evt(n);
    chk("buffered period", 16'h000A, 16'(n));
    meas(10);
    chk("buffered duty", 16'h0007, 16'(hc[0]));
    chk("pair fault", 16'h0000, 16'(flt));
    $display("test edge aligned done");
    foreach (modes[i]) begin
      cfg(modes[i].c, 16'h0004, 16'h0002, 16'h0000, 16'h0005);
      wait_evt(n);
      wait_evt(n);
      chk("event interval", modes[i].n, 16'(n));
    end
    $display("test modes done");
    cfg(16'h800A, 16'h0008, 16'h0004, 16'h0000, 16'h0008);
    rreg(mpt_pkg::OFS_CONTROL, v1);
    chk("control enable", 16'h800A, v1);
    wait_evt(n);
    meas(288);
    chk("centre duty 4", 16'h0090, 16'(hc[0]));
    chk("centre duty 0", 16'h0000, 16'(hc[1]));
    chk("centre duty full", 16'h0120, 16'(hc[2]));
    wait_evt(n);
    rreg(mpt_pkg::OFS_COUNT, v1);
    chk("count at turn", 16'h0000, v1);
    idle(178);
    rreg(mpt_pkg::OFS_COUNT, v1);
    chk("count going down", 16'h8006, v1);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    meas(20);
    chk("events after reset", 16'h0000, 16'(ev + hc[0] + hc[1] + hc[2]));
    rreg(mpt_pkg::OFS_COUNT, v1);
    chk("count after second reset", 16'h0000, v1);
    $display("test centre aligned done");
    cfg(16'h8001, 16'h0004, 16'h0002, 16'h0000, 16'h0005);
    meas(40);
    chk("single shot events", 16'h0001, 16'(ev));
    rreg(mpt_pkg::OFS_CONTROL, v1);
    chk("single shot enable", 16'h0001, v1);
    rreg(mpt_pkg::OFS_COUNT, v1);
    chk("single shot count", 16'h0000, v1);
    cfg(16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    meas(30);
    chk("zero period events", 16'h0000, 16'(ev));
    // Timer must survive the disabling control write
    cfg(16'h8004, 16'h0009, 16'h0002, 16'h0000, 16'h0005);
    idle(13);
    wreg(mpt_pkg::OFS_CONTROL, 16'h0004);
    rreg(mpt_pkg::OFS_COUNT, v1);
    idle(20);
    rreg(mpt_pkg::OFS_COUNT, v2);
    chk("frozen count", v1, v2);
    chk("count kept", 16'h0003, v1);
    $display("test single shot and freeze done");
    end_sim;
  end
endmodule // mpt_time_base_tb_top

bind mpt_time_base mpt_time_base_chk #(.NUM_CH(NUM_CH)) chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_tb_event(o_tb_event), .o_pair_high_out(o_pair_high_out), .o_pair_low_out(o_pair_low_out));
